//--- logic/drive_ctrl_pkg.sv
// Purpose: Shared constants for the drive supervisory control block
// Assumes: 200 MHz clock, settings arrive as plain ports
// Notes: Frequencies in 0.1 Hz units, analogue levels in 0.1 % units, boost in whole percent
package drive_ctrl_pkg;
  // Clock rate and one-second tick
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  // Trip reset mode codes
  localparam logic [3:0] RESET_MANUAL = 4'h0;
  localparam logic [3:0] RESET_X10 = 4'h6;
  localparam logic [3:0] RESET_X15 = 4'h7;
  localparam logic [3:0] RESET_X20 = 4'h8;
  localparam logic [3:0] RESET_INFINITE = 4'h9;
  // Restart delay limits and default, seconds
  localparam logic [10:0] RESTART_DELAY_MAX = 11'h708;
  localparam logic [10:0] RESTART_DELAY_DEF = 11'h00a;
  // Flying start codes; brake-then-start code is unconfirmed
  localparam logic [1:0] FLY_DISABLE = 2'h0;
  localparam logic [1:0] FLY_ENABLE = 2'h1;
  localparam logic [1:0] FLY_BRAKE_START = 2'h3;
  // Sleep timer: 0..300 s, 301 means off
  localparam logic [8:0] SLEEP_TIMER_MAX = 9'h12c;
  localparam logic [8:0] SLEEP_TIMER_OFF = 9'h12d;
  // Frequency defaults, 0.1 Hz units
  localparam logic [15:0] SLEEP_FREQ_DEF = 16'h0000;
  localparam logic [15:0] RESUME_FREQ_DEF = 16'h01f4;
  // Boost setpoint limits, percent
  localparam logic [7:0] BOOST_MIN = 8'h01;
  localparam logic [7:0] BOOST_MAX = 8'hc8;
  localparam logic [7:0] BOOST_DEF = 8'h64;
  // Noise method code for fixed switching rate
  localparam logic [1:0] NOISE_FIXED = 2'h1;
  // Derating threshold, switch rate in 0.1 kHz units
  localparam logic [15:0] DERATE_THRESHOLD = 16'h002d;
  // Bus analogue outputs, 0.1 % units, full scale 100.0 %
  localparam logic [9:0] AOUT_MAX = 10'h3e8;
endpackage

//--- logic/sec_tick.sv
// Purpose: One-second enable pulse divider
// Assumes: Single clock, synchronous active-high reset
// Notes: Period is a parameter so simulation can shorten it
`timescale 1ns/100ps
module sec_tick import drive_ctrl_pkg::*; #(
  parameter int unsigned PERIOD = SEC_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic tick
);
  // Divider count
  logic [31:0] cnt_q;

  // Elaboration check: below 2 the pulse would never drop
  if (PERIOD < 2) begin : g_period_check
    $error("PERIOD must be at least 2");
  end

  // Free-running count, pulse at wrap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else if (cnt_q == 32'(PERIOD - 1)) begin
      cnt_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule

//--- logic/drive_sleep_restart_control.sv
// Purpose: Trip reset, flying start, sleep mode and switching limits
// Assumes: Settings are static plain ports; pins pass 3-flop sync
// Notes: Frequencies 0.1 Hz, switch rate 0.1 kHz, boost in percent
`timescale 1ns/100ps
module drive_sleep_restart_control import drive_ctrl_pkg::*; #(
  parameter int unsigned SEC_PERIOD = SEC_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic trip_in,
  input wire logic reset_key,
  input wire logic reset_pin,
  input wire logic start_cmd,
  input wire logic restart_ok,
  input wire logic [3:0] trip_reset_mode,
  input wire logic [10:0] restart_delay,
  input wire logic [1:0] fly_mode,
  input wire logic local_or_jog,
  input wire logic closed_loop,
  input wire logic [8:0] sleep_timer,
  input wire logic [15:0] sleep_frequency,
  input wire logic [15:0] resume_frequency,
  input wire logic [15:0] max_frequency,
  input wire logic [15:0] min_frequency,
  input wire logic [15:0] theoretical_freq,
  input wire logic [15:0] motor_speed,
  input wire logic [7:0] boost_setpoint,
  input wire logic [8:0] boost_timeout,
  input wire logic boost_reached,
  input wire logic [1:0] noise_method,
  input wire logic [15:0] inverter_switch_rate,
  input wire logic [15:0] auto_switch_rate,
  input wire logic bus_write,
  input wire logic bus_sel,
  input wire logic [9:0] bus_level,
  input wire logic panel_read,
  output logic tripped,
  output logic auto_reset_pulse,
  output logic catch_motor,
  output logic dc_brake,
  output logic ramp_down,
  output logic sleeping,
  output logic [15:0] out_freq,
  output logic [7:0] boost_pct,
  output logic [15:0] switch_rate,
  output logic derate,
  output logic [9:0] aout_42,
  output logic [9:0] aout_45,
  output logic panel_visible
);
  typedef enum logic [1:0] {RUN, BOOST, RAMP, SLEEP} sleep_e;

  // Pin inputs pass three flops; change counts when stages 2,3 agree
  logic [2:0] trip_s, key_s, pin_s, start_s;
  logic trip_f, key_f, pin_f, start_f;
  logic tick;
  // Trip handling state
  logic [4:0] attempts_q;
  logic [10:0] delay_q;
  logic waiting_q;
  // Sleep machine
  sleep_e st_q;
  logic [8:0] stimer_q;
  logic [8:0] btimer_q;
  logic brake_done_q;

  // Attempt count for a mode; 31 marks unlimited
  function automatic logic [4:0] attempt_limit(input logic [3:0] m);
    case (m)
      RESET_X10: attempt_limit = 5'd10;
      RESET_X15: attempt_limit = 5'd15;
      RESET_X20: attempt_limit = 5'd20;
      RESET_INFINITE: attempt_limit = 5'h1f;
      default: attempt_limit = (m > RESET_INFINITE) ? 5'h0 : {1'b0, m};
    endcase
  endfunction

  // Clamp a value into [lo, hi]
  function automatic logic [15:0] clamp(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  sec_tick #(.PERIOD(SEC_PERIOD)) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // Input synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trip_s <= 3'h0;
      key_s <= 3'h0;
      pin_s <= 3'h0;
      start_s <= 3'h0;
      trip_f <= 1'b0;
      key_f <= 1'b0;
      pin_f <= 1'b0;
      start_f <= 1'b0;
    end else begin
      trip_s <= {trip_s[1:0], trip_in};
      key_s <= {key_s[1:0], reset_key};
      pin_s <= {pin_s[1:0], reset_pin};
      start_s <= {start_s[1:0], start_cmd};
      if (trip_s[1] == trip_s[2]) trip_f <= trip_s[2];
      if (key_s[1] == key_s[2]) key_f <= key_s[2];
      if (pin_s[1] == pin_s[2]) pin_f <= pin_s[2];
      if (start_s[1] == start_s[2]) start_f <= start_s[2];
    end
  end

  // Effective settings, limited to legal ranges
  logic [10:0] delay_eff;
  logic [15:0] sleep_eff, resume_eff, theo_cap;
  logic [8:0] stimer_eff;
  logic [4:0] limit;
  logic manual_clr, timer_on;
  always_comb begin
    delay_eff = (restart_delay > RESTART_DELAY_MAX) ?
      RESTART_DELAY_MAX : restart_delay;
    resume_eff = (resume_frequency > max_frequency) ?
      max_frequency : resume_frequency;
    sleep_eff = (sleep_frequency > resume_eff) ?
      resume_eff : sleep_frequency;
    stimer_eff = (sleep_timer > SLEEP_TIMER_OFF) ?
      SLEEP_TIMER_OFF : sleep_timer;
    timer_on = (stimer_eff != SLEEP_TIMER_OFF);
    limit = attempt_limit(trip_reset_mode);
    manual_clr = key_f | pin_f;
    theo_cap = clamp(theoretical_freq, min_frequency, max_frequency);
  end

  // Trip latch, automatic attempts and restart delay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tripped <= 1'b0;
      waiting_q <= 1'b0;
      attempts_q <= 5'h0;
      delay_q <= 11'h0;
      auto_reset_pulse <= 1'b0;
    end else begin
      auto_reset_pulse <= 1'b0;
      if (trip_f && !tripped) begin
        // New trip wins over any clear in this cycle
        tripped <= 1'b1;
        delay_q <= 11'h0;
        waiting_q <= (trip_reset_mode != RESET_MANUAL) &&
          ((limit == 5'h1f) || (attempts_q < limit));
      end else if (tripped && manual_clr) begin
        tripped <= 1'b0;
        waiting_q <= 1'b0;
        attempts_q <= 5'h0;
      end else if (waiting_q && tick) begin
        if (delay_q >= delay_eff) begin
          tripped <= 1'b0;
          waiting_q <= 1'b0;
          auto_reset_pulse <= 1'b1;
          if (limit != 5'h1f) attempts_q <= attempts_q + 5'h1;
        end else begin
          delay_q <= delay_q + 11'h1;
        end
      end else if (!tripped && restart_ok) begin
        attempts_q <= 5'h0; // Successful restart refills attempts
      end
    end
  end

  // Flying start and brake-then-start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      catch_motor <= 1'b0;
      dc_brake <= 1'b0;
      brake_done_q <= 1'b0;
    end else begin
      catch_motor <= start_f && !tripped && (fly_mode == FLY_ENABLE) &&
        (motor_speed < max_frequency);
      if (!start_f || tripped) begin
        dc_brake <= 1'b0;
        brake_done_q <= 1'b0;
      end else if (fly_mode == FLY_BRAKE_START && !brake_done_q) begin
        // Brake until the next one-second tick, then hand over to a normal start
        dc_brake <= 1'b1;
        if (tick && dc_brake) begin
          dc_brake <= 1'b0;
          brake_done_q <= 1'b1;
        end
      end else begin
        dc_brake <= 1'b0;
      end
    end
  end

  // Sleep state machine
  always_ff @(posedge clk) begin
    if (sys_rst || local_or_jog || tripped) begin
      st_q <= RUN;
      stimer_q <= 9'h0;
      btimer_q <= 9'h0;
    end else begin
      case (st_q)
        RUN: begin
          if (!timer_on || out_freq > sleep_eff) begin
            stimer_q <= 9'h0;
          end else if (out_freq < sleep_eff) begin
            if (stimer_q >= stimer_eff) begin
              // boost only in closed loop and when not at 100 %
              st_q <= (closed_loop && boost_pct != BOOST_DEF) ?
                BOOST : RAMP;
              btimer_q <= 9'h0;
            end else if (tick) begin
              stimer_q <= stimer_q + 9'h1;
            end
          end
        end
        BOOST: begin
          if (boost_reached) st_q <= RAMP;
          else if (btimer_q >= boost_timeout) begin
            st_q <= RUN;
            stimer_q <= 9'h0;
          end else if (tick) btimer_q <= btimer_q + 9'h1;
        end
        RAMP: begin
          if (out_freq == 16'h0) st_q <= SLEEP;
        end
        SLEEP: begin
          if (theoretical_freq > resume_eff) begin
            st_q <= RUN;
            stimer_q <= 9'h0;
          end
        end
        default: st_q <= RUN;
      endcase
    end
  end

  // Status outputs of the sleep machine
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramp_down <= 1'b0;
      sleeping <= 1'b0;
      boost_pct <= BOOST_DEF;
    end else begin
      ramp_down <= (st_q == RAMP);
      sleeping <= (st_q == SLEEP);
      if (!closed_loop) boost_pct <= BOOST_DEF;
      else if (boost_setpoint < BOOST_MIN) boost_pct <= BOOST_MIN;
      else if (boost_setpoint > BOOST_MAX) boost_pct <= BOOST_MAX;
      else boost_pct <= boost_setpoint;
    end
  end

  // Switching rate selection and derating
  logic [15:0] rate_sel, freq_cap, freq_raw;
  always_comb begin
    rate_sel = (noise_method == NOISE_FIXED) ?
      inverter_switch_rate : auto_switch_rate;
    // Tenth of rate is r x 100 in 0.1 Hz; saturate, never wrap
    freq_cap = (rate_sel > 16'h028f) ? 16'hffff :
      16'(rate_sel * 16'h0064);
    if (st_q == RAMP || st_q == SLEEP) freq_raw = 16'h0;
    else freq_raw = theo_cap; // Follows theoretical, floored at min
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      switch_rate <= 16'h0;
      derate <= 1'b0;
      out_freq <= 16'h0;
    end else begin
      switch_rate <= rate_sel;
      derate <= (rate_sel > DERATE_THRESHOLD);
      out_freq <= (freq_raw > freq_cap) ? freq_cap : freq_raw;
    end
  end

  // Bus-written analogue outputs; panel never sees them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aout_42 <= 10'h0;
      aout_45 <= 10'h0;
      panel_visible <= 1'b0;
    end else begin
      panel_visible <= 1'b0;
      if (bus_write && !bus_sel)
        aout_42 <= (bus_level > AOUT_MAX) ? AOUT_MAX : bus_level;
      if (bus_write && bus_sel)
        aout_45 <= (bus_level > AOUT_MAX) ? AOUT_MAX : bus_level;
    end
  end

  chk_out_cap: assert property (@(posedge clk) disable iff (sys_rst)
    24'(out_freq) <= 24'(switch_rate) * 24'h000064) else $error("above cap");
  chk_derate_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (rate_sel > DERATE_THRESHOLD) |=> derate) else $error("no derate");
  chk_no_sleep_local: assert property (@(posedge clk)
    disable iff (sys_rst) local_or_jog |=> ##1 !sleeping)
    else $error("sleep in local");
  chk_manual_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (tripped && trip_reset_mode == RESET_MANUAL && !manual_clr &&
     !waiting_q) |=> tripped) else $error("manual trip cleared");
  chk_boost_open: assert property (@(posedge clk) disable iff (sys_rst)
    !closed_loop |=> boost_pct == BOOST_DEF) else $error("boost in open");
  chk_wake_exit: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == SLEEP && theoretical_freq > resume_eff && !local_or_jog
     && !tripped) |=> st_q == RUN) else $error("no wake");
  chk_fly_catch: assert property (@(posedge clk) disable iff (sys_rst)
    catch_motor |-> $past(motor_speed) < $past(max_frequency))
    else $error("catch above max");
  chk_panel_hidden: assert property (@(posedge clk)
    disable iff (sys_rst) ##1 !panel_visible) else $error("panel sees levels");
  chk_rate_fixed: assert property (@(posedge clk) disable iff (sys_rst)
    (noise_method == NOISE_FIXED) |=>
    switch_rate == $past(inverter_switch_rate)) else $error("rate not fixed");
endmodule

//--- verification/bus_panel_model.sv
// Purpose: Serial bus master and operator panel stand-in
// Assumes: Requests change just after the falling clock edge
// Notes: Panel only polls; analogue levels come over the link
`timescale 1ns/100ps
module bus_panel_model (
  input wire logic clk,
  output logic bus_write,
  output logic bus_sel,
  output logic [9:0] bus_level,
  output logic panel_read
);
  // Idle: no strobe, data shows a junk pattern
  initial begin
    bus_write = 1'b0;
    bus_sel = 1'b0;
    bus_level = 10'h155;
    panel_read = 1'b0;
  end
  // One link write, strobe and data held for one full cycle
  task automatic write_level(input logic sel, input logic [9:0] lvl);
    @(negedge clk);
    bus_write = 1'b1;
    bus_sel = sel;
    bus_level = lvl;
    @(negedge clk);
    bus_write = 1'b0;
    // Released data must not look like the last value
    bus_level = ~lvl;
  endtask
  // Panel poll; the bus levels must stay hidden from it
  task automatic panel_poll();
    @(negedge clk);
    panel_read = 1'b1;
    @(negedge clk);
    panel_read = 1'b0;
  endtask
endmodule

//--- verification/drive_sleep_restart_control_tb.sv
// Purpose: Self-checking bench for the drive supervisory control
// Assumes: Second tick shortened to P cycles, inputs at falling edge
// Notes: Trip and reset pins pass a sync, so checks allow a few cycles
`timescale 1ns/100ps
module drive_sleep_restart_control_tb;
  import drive_ctrl_pkg::*;
  localparam int unsigned P = 10; // Cycles per simulated second
  // Inputs idle at time zero; tests change them
  logic clk = 1'b0, sys_rst = 1'b1, trip_in = 1'b0, reset_key = 1'b0;
  logic reset_pin = 1'b0, start_cmd = 1'b0, restart_ok = 1'b0;
  logic local_or_jog = 1'b0, closed_loop = 1'b0, boost_reached = 1'b0;
  logic [3:0] trip_reset_mode = 4'h0;
  logic [10:0] restart_delay = 11'h002; // Two seconds per attempt
  logic [1:0] fly_mode = 2'h0, noise_method = 2'h1;
  logic [8:0] sleep_timer = 9'h12d, boost_timeout = 9'h005;
  logic [15:0] sleep_frequency = 16'h0064, resume_frequency = 16'h00c8;
  logic [15:0] max_frequency = 16'h01f4, min_frequency = 16'h0000;
  logic [15:0] theoretical_freq = 16'h0190, motor_speed = 16'h0000;
  logic [15:0] inverter_switch_rate = 16'h00c8;
  logic [15:0] auto_switch_rate = 16'h0032;
  logic [7:0] boost_setpoint = 8'h64;
  // Partner-driven link and panel lines
  wire bus_write, bus_sel, panel_read;
  wire [9:0] bus_level;
  // Design outputs
  logic tripped, auto_reset_pulse, catch_motor, dc_brake, ramp_down;
  logic sleeping, derate, panel_visible;
  logic [15:0] out_freq, switch_rate;
  logic [7:0] boost_pct;
  logic [9:0] aout_42, aout_45;
  int n_mismatch = 0, checked = 0, cyc = 0;
  // Automatic attempts granted per reset mode; unlimited tried three times in the loop, then once more
  int cnt [10] = '{0, 1, 2, 3, 4, 5, 10, 15, 20, 3};

  drive_sleep_restart_control #(.SEC_PERIOD(P)) dut_u (.*);
  bus_panel_model bm_u (.*);

  // 200 MHz clock
  initial forever #2.5 clk = ~clk;

  // Verdict and end of run, used by the hang guard as well
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Compare and count; four-state equality so X never matches
  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for a level, then compare
  task automatic wait_is(input string what, ref logic s, input logic v,
      input int n);
    for (int k = 0; k < n && s !== v; k++) @(negedge clk);
    chk(what, 16'(v), 16'(s));
  endtask
  // Reset held three cycles
  task automatic do_reset();
    @(negedge clk);
    sys_rst = 1'b1;
    settle(3);
    sys_rst = 1'b0;
    @(negedge clk);
  endtask
  // Long enough to pass the pin synchroniser
  task automatic pulse(ref logic s);
    s = 1'b1;
    settle(6);
    s = 1'b0;
  endtask
  // One trip; attempt must not come early, and comes or not as asked
  task automatic trip_once(input logic exp_auto);
    logic seen;
    seen = 1'b0;
    pulse(trip_in);
    chk("tripped", 16'h0001, 16'(tripped));
    repeat (P) begin
      @(negedge clk);
      seen = seen | auto_reset_pulse;
    end
    chk("early attempt", 16'h0000, 16'(seen));
    repeat (4 * P) begin
      @(negedge clk);
      seen = seen | auto_reset_pulse;
    end
    chk("attempt", 16'(exp_auto), 16'(seen));
    chk("trip left", 16'(!exp_auto), 16'(tripped));
  endtask

  // Hang guard: whole run needs well under 10000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    do_reset();
    chk("boost_pct", 16'h0064, 16'(boost_pct));
    chk("tripped", 16'h0000, 16'(tripped));
    $display("test reset done");
    // Two link writes one idle cycle apart, second one beyond full scale
    bm_u.write_level(1'b0, 10'h1f4);
    bm_u.write_level(1'b1, 10'h3ff);
    settle(2);
    chk("aout_42", 16'h01f4, 16'(aout_42));
    chk("aout_45", 16'(AOUT_MAX), 16'(aout_45));
    bm_u.panel_poll();
    chk("panel_visible", 16'h0000, 16'(panel_visible));
    $display("test bus done");
    // Every reset mode: its attempts, then refusal (mode 9 grants one more) and manual clear
    for (int m = 0; m < 10; m++) begin
      do_reset();
      trip_reset_mode = 4'(m);
      for (int k = 0; k < cnt[m]; k++) begin
        trip_once(1'b1);
      end
      trip_once(m == 9);
      if (m[0]) pulse(reset_pin);
      else pulse(reset_key);
      settle(4);
      chk("cleared", 16'h0000, 16'(tripped));
    end
    $display("test trip reset done");
    // Flying start only below the top output frequency
    start_cmd = 1'b1;
    motor_speed = 16'h0064;
    fly_mode = FLY_ENABLE;
    settle(8);
    chk("catch", 16'h0001, 16'(catch_motor));
    motor_speed = 16'h0258;
    settle(8);
    chk("catch fast", 16'h0000, 16'(catch_motor));
    motor_speed = 16'h0064;
    fly_mode = FLY_DISABLE;
    settle(8);
    chk("catch off", 16'h0000, 16'(catch_motor));
    start_cmd = 1'b0;
    fly_mode = FLY_BRAKE_START;
    settle(8);
    start_cmd = 1'b1;
    wait_is("dc_brake", dc_brake, 1'b1, 20);
    wait_is("dc_brake end", dc_brake, 1'b0, 2 * P);
    $display("test flying start done");
    // Switching limits: fixed rate, tenth cap, derate above 4.5 kHz
    theoretical_freq = 16'h1388;
    max_frequency = 16'hffff;
    inverter_switch_rate = 16'h0005;
    settle(8);
    chk("switch_rate", 16'h0005, switch_rate);
    chk("cap", 16'h01f4, out_freq);
    inverter_switch_rate = 16'h002d;
    settle(4);
    chk("derate at 4.5", 16'h0000, 16'(derate));
    inverter_switch_rate = 16'h002e;
    settle(4);
    chk("derate at 4.6", 16'h0001, 16'(derate));
    noise_method = 2'h0;
    settle(4);
    chk("auto rate", 16'h0032, switch_rate);
    // Boost setpoint ignored in open loop
    boost_setpoint = 8'h7d;
    settle(4);
    chk("boost open", 16'h0064, 16'(boost_pct));
    closed_loop = 1'b1;
    settle(4);
    chk("boost closed", 16'h007d, 16'(boost_pct));
    $display("test limits done");
    // Sleep: blocked locally, off code, timer clearing, wake
    do_reset();
    closed_loop = 1'b0;
    noise_method = NOISE_FIXED;
    inverter_switch_rate = 16'h00c8;
    max_frequency = 16'h01f4;
    theoretical_freq = 16'h0032;
    local_or_jog = 1'b1;
    sleep_timer = 9'h002;
    settle(6 * P);
    chk("ramp local", 16'h0000, 16'(ramp_down));
    chk("out_freq", 16'h0032, out_freq);
    min_frequency = 16'h0046;
    settle(4);
    chk("out_freq min", 16'h0046, out_freq);
    min_frequency = 16'h0000;
    local_or_jog = 1'b0;
    sleep_timer = SLEEP_TIMER_OFF;
    settle(6 * P);
    chk("ramp off", 16'h0000, 16'(ramp_down));
    theoretical_freq = 16'h0096;
    settle(4);
    sleep_timer = 9'h002;
    // Dips shorter than the timer must never expire it
    for (int k = 0; k < 6; k++) begin
      theoretical_freq = 16'h0032;
      settle(6);
      theoretical_freq = 16'h0096;
      settle(3);
    end
    chk("ramp cleared", 16'h0000, 16'(ramp_down));
    theoretical_freq = 16'h0032;
    wait_is("ramp_down", ramp_down, 1'b1, 4 * P);
    wait_is("sleeping", sleeping, 1'b1, 2000);
    theoretical_freq = 16'h012c;
    wait_is("awake", sleeping, 1'b0, 40);
    // Closed loop with boost: no ramp until boost is reached
    closed_loop = 1'b1;
    theoretical_freq = 16'h0032;
    settle(8 * P);
    chk("ramp boosting", 16'h0000, 16'(ramp_down));
    boost_reached = 1'b1;
    wait_is("ramp boosted", ramp_down, 1'b1, 4 * P);
    $display("test sleep done");
    results();
  end
endmodule
